//--- dbtc_top.sv
// Output-loop bandwidth select, integral limit freeze and crystal trim low byte registers
//
// Behaviour
// RULE1: Auto-pick bit 7 set lets loop state choose acquisition bandwidth; clear forces locked.
// RULE2: Limit freeze bit 3 set holds the integral value at min or max frequency.
// RULE3: While integral is held, the reported loop frequency is frozen too.
// RULE4: An 8-bit read/write register holds calibration value bits 7 to 0.
// RULE5: Low calibration byte resets to 1001 1001.
// RULE6: Low and high bytes join into an unsigned 16-bit trim, +514 to -771 ppm.
// RULE7: Default combined trim means zero offset from 12.800 MHz.
// RULE8: Unused bandwidth register bits ignore writes and read their defaults.
`timescale 1ns/1ps
`default_nettype none
module dbtc_top
#(
  parameter int FREQ_W = 16
)(
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire dbtc_pkg::dbtc_req_t    REG_REQ,
  output logic      [7:0]             RD_DATA,
  output logic                        RD_VALID,
  input  wire logic                   LOOP_LOCKED,
  input  wire logic                   INTEG_AT_LIMIT,
  input  wire logic [FREQ_W-1:0]      LOOP_FREQ,
  input  wire logic [7:0]             TRIM_HIGH,
  output logic                        USE_ACQ_BW,
  output logic                        INTEG_HOLD,
  output logic      [FREQ_W-1:0]      REPORTED_FREQ,
  output logic      [15:0]            CAL_VALUE
);
  import dbtc_pkg::*;

  logic              auto_r, auto_nxt;
  logic              frz_r, frz_nxt;
  logic [7:0]        low_r, low_nxt;
  logic [7:0]        rd_r, rd_nxt;
  logic              rv_r, rv_nxt;
  logic              acq_r, acq_nxt;
  logic              hold_r, hold_nxt;
  logic [FREQ_W-1:0] freq_r, freq_nxt;
  logic [15:0]       cal_r, cal_nxt;

  // ==========================================================================
  // Read image: unused bits are constants from the reset pattern
  function automatic logic [7:0] bw_image(input logic a, input logic f);
    logic [7:0] v;
    v = DBTC_BW_RESET;
    v[DBTC_BIT_AUTO_PICK]  = a;
    v[DBTC_BIT_LIM_FREEZE] = f;
    return v;
  endfunction

  // ==========================================================================
  // Register writes and reads
  always_comb
  begin
    auto_nxt = auto_r;
    frz_nxt  = frz_r;
    low_nxt  = low_r;
    rd_nxt   = rd_r;
    rv_nxt   = REG_REQ.rd;
    if (REG_REQ.wr && REG_REQ.addr == DBTC_ADDR_BW_SELECT)
    begin
      auto_nxt = REG_REQ.wdata[DBTC_BIT_AUTO_PICK];  // RULE8
      frz_nxt  = REG_REQ.wdata[DBTC_BIT_LIM_FREEZE];
    end
    if (REG_REQ.wr && REG_REQ.addr == DBTC_ADDR_TRIM_LOW)
      low_nxt = REG_REQ.wdata;  // RULE4
    // Reads show the value before a same-cycle write
    if (REG_REQ.rd)
    begin
      case (REG_REQ.addr)
        DBTC_ADDR_BW_SELECT: rd_nxt = bw_image(auto_r, frz_r);  // RULE8
        DBTC_ADDR_TRIM_LOW:  rd_nxt = low_r;  // RULE4
        default:             rd_nxt = DBTC_RD_UNMAPPED;
      endcase
    end
  end

  // ==========================================================================
  // Loop steering; freezing the report in the same cycle as the hold keeps them aligned
  always_comb
  begin
    acq_nxt  = auto_r & ~LOOP_LOCKED;  // RULE1
    hold_nxt = frz_r & INTEG_AT_LIMIT;  // RULE2
    freq_nxt = hold_nxt ? freq_r : LOOP_FREQ;  // RULE3
    cal_nxt  = {TRIM_HIGH, low_nxt};  // RULE6 RULE7
  end

  // ==========================================================================
  // Register bank flops; reset brings back the power-up defaults
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      auto_r <= DBTC_BW_RESET[DBTC_BIT_AUTO_PICK];
      frz_r  <= DBTC_BW_RESET[DBTC_BIT_LIM_FREEZE];
      low_r  <= DBTC_TRIM_LOW_RESET;  // RULE5
      rd_r   <= DBTC_RD_UNMAPPED;
      rv_r   <= 1'b0;
    end
    else
    begin
      auto_r <= auto_nxt;
      frz_r  <= frz_nxt;
      low_r  <= low_nxt;
      rd_r   <= rd_nxt;
      rv_r   <= rv_nxt;
    end
  end

  // ==========================================================================
  // Loop steering flops; the trim word restarts at the zero-offset code
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      acq_r  <= 1'b0;
      hold_r <= 1'b0;
      freq_r <= '0;
      cal_r  <= DBTC_TRIM_ZERO_PPM;  // RULE7
    end
    else
    begin
      acq_r  <= acq_nxt;
      hold_r <= hold_nxt;
      freq_r <= freq_nxt;
      cal_r  <= cal_nxt;
    end
  end

  // Outputs straight from flops
  assign RD_DATA       = rd_r;
  assign RD_VALID      = rv_r;
  assign USE_ACQ_BW    = acq_r;
  assign INTEG_HOLD    = hold_r;
  assign REPORTED_FREQ = freq_r;
  assign CAL_VALUE     = cal_r;

  // ==========================================================================
  // Checks
  property p_locked_only;
    @(posedge CLK) disable iff (!RST_N)
      !auto_r |=> !USE_ACQ_BW;
  endproperty
  a_locked_only: assert property (p_locked_only) else $error("acq bw used while auto off"); // RULE1

  property p_acq_unlocked;
    @(posedge CLK) disable iff (!RST_N) (auto_r && !LOOP_LOCKED) |=> USE_ACQ_BW;
  endproperty
  a_acq_unlocked: assert property (p_acq_unlocked) else $error("acq bw missing"); // RULE1

  property p_hold_at_limit;
    @(posedge CLK) disable iff (!RST_N) (frz_r && INTEG_AT_LIMIT) |=> INTEG_HOLD;
  endproperty
  a_hold_at_limit: assert property (p_hold_at_limit) else $error("integral not held"); // RULE2

  property p_no_hold;
    @(posedge CLK) disable iff (!RST_N) !frz_r |=> !INTEG_HOLD;
  endproperty
  a_no_hold: assert property (p_no_hold) else $error("hold without freeze bit"); // RULE2

  property p_freq_frozen;
    @(posedge CLK) disable iff (!RST_N) INTEG_HOLD && $past(RST_N) |-> $stable(REPORTED_FREQ);
  endproperty
  a_freq_frozen: assert property (p_freq_frozen) else $error("report moved while held"); // RULE3

  property p_trim_write;
    @(posedge CLK) disable iff (!RST_N)
      (REG_REQ.wr && REG_REQ.addr == DBTC_ADDR_TRIM_LOW) |=>
        (CAL_VALUE[7:0] == $past(REG_REQ.wdata)) && (CAL_VALUE[15:8] == $past(TRIM_HIGH));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim word wrong"); // RULE4 RULE6

  property p_trim_reset;
    @(posedge CLK) !RST_N |=> (low_r == DBTC_TRIM_LOW_RESET);
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim low reset wrong"); // RULE5

  property p_bw_unused;
    @(posedge CLK) disable iff (!RST_N)
      (REG_REQ.rd && REG_REQ.addr == DBTC_ADDR_BW_SELECT) |=>
        RD_VALID && (RD_DATA[6:4] == DBTC_BW_RESET[6:4]) && (RD_DATA[2:0] == DBTC_BW_RESET[2:0]);
  endproperty
  a_bw_unused: assert property (p_bw_unused) else $error("unused bits read wrong"); // RULE8

  property p_unmapped;
    @(posedge CLK) disable iff (!RST_N)
      (REG_REQ.rd && REG_REQ.addr != DBTC_ADDR_BW_SELECT && REG_REQ.addr != DBTC_ADDR_TRIM_LOW)
        |=> (RD_DATA == DBTC_RD_UNMAPPED);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // A bandwidth write lands in both control bits on the next edge
  property p_bw_write;
    @(posedge CLK) disable iff (!RST_N)
      (REG_REQ.wr && REG_REQ.addr == DBTC_ADDR_BW_SELECT) |=>
        (auto_r == $past(REG_REQ.wdata[DBTC_BIT_AUTO_PICK])) &&
        (frz_r == $past(REG_REQ.wdata[DBTC_BIT_LIM_FREEZE]));
  endproperty
  a_bw_write: assert property (p_bw_write) else $error("bandwidth bits not written"); // RULE1 RULE2

  property p_trim_kept;
    @(posedge CLK) disable iff (!RST_N)
      !(REG_REQ.wr && REG_REQ.addr == DBTC_ADDR_TRIM_LOW) |=> $stable(low_r);
  endproperty
  a_trim_kept: assert property (p_trim_kept) else $error("trim low moved without write"); // RULE4

  property p_cal_track;
    @(posedge CLK) disable iff (!RST_N) 1'b1 |=> (CAL_VALUE == {$past(TRIM_HIGH), low_r});
  endproperty
  a_cal_track: assert property (p_cal_track) else $error("trim word not joined"); // RULE6

  // Without a hold the report must follow the live loop with one cycle of lag
  property p_freq_track;
    @(posedge CLK) disable iff (!RST_N)
      !(frz_r && INTEG_AT_LIMIT) |=> (REPORTED_FREQ == $past(LOOP_FREQ));
  endproperty
  a_freq_track: assert property (p_freq_track) else $error("report not tracking"); // RULE2 RULE3

  property p_rd_pulse;
    @(posedge CLK) disable iff (!RST_N) !REG_REQ.rd |=> !RD_VALID;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid without read"); // RULE4

  property p_rd_trim;
    @(posedge CLK) disable iff (!RST_N)
      (REG_REQ.rd && REG_REQ.addr == DBTC_ADDR_TRIM_LOW) |=>
        RD_VALID && (RD_DATA == $past(low_r));
  endproperty
  a_rd_trim: assert property (p_rd_trim) else $error("trim low read wrong"); // RULE4

  // ==========================================================================
  // Cover points for the main scenarios
  c_hold: cover property (@(posedge CLK) disable iff (!RST_N) INTEG_HOLD [*3]);
  c_acq: cover property (@(posedge CLK) disable iff (!RST_N) USE_ACQ_BW ##1 !USE_ACQ_BW);
  c_trim: cover property (@(posedge CLK) disable iff (!RST_N)
    (REG_REQ.wr && REG_REQ.addr == DBTC_ADDR_TRIM_LOW) ##1 REG_REQ.rd);
  c_locked_only: cover property (@(posedge CLK) disable iff (!RST_N)
    (!auto_r && !LOOP_LOCKED) ##1 !USE_ACQ_BW);
endmodule
`default_nettype wire

//--- dbtc_pkg.sv
// Package: register map, field positions, reset values and carriers of the loop trim config
`default_nettype none
package dbtc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] DBTC_ADDR_TRIM_LOW  = 8'h3c;
  localparam logic [7:0] DBTC_ADDR_BW_SELECT = 8'h3b;
  // ==========================================================================
  // Field positions and reset values
  localparam int         DBTC_BIT_AUTO_PICK  = 7;
  localparam int         DBTC_BIT_LIM_FREEZE = 3;
  localparam logic [7:0] DBTC_BW_RESET       = 8'hfd;
  localparam logic [7:0] DBTC_TRIM_LOW_RESET = 8'h99;
  localparam logic [7:0] DBTC_RD_UNMAPPED    = 8'h00;
  // ==========================================================================
  // Calibration range: default word is zero offset from the nominal crystal
  localparam int         DBTC_TRIM_PPM_UP    = 514;
  localparam int         DBTC_TRIM_PPM_DOWN  = -771;
  localparam int         DBTC_XTAL_NOM_KHZ   = 12800;
  localparam logic [15:0] DBTC_TRIM_ZERO_PPM = 16'h9999;
  // ==========================================================================
  // Register access request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } dbtc_req_t;
endpackage
`default_nettype wire

//--- dbtc_top_tb.sv
// Self-checking testbench for the loop bandwidth select and crystal trim registers
`timescale 1ns/1ps
`default_nettype none
module dbtc_top_tb;
  import dbtc_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } dbtc_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  dbtc_req_t   req = '0;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        locked = 1'b1;
  logic        at_lim = 1'b0;
  logic [15:0] freq = 16'h0000;
  logic [7:0]  trim_hi = 8'h99;
  logic        use_acq;
  logic        hold;
  logic [15:0] rep_freq;
  logic [15:0] cal;
  int          mismatches = 0;
  int          checks_done = 0;
  // Write, then read back; unused bandwidth bits keep 0xfd pattern
  dbtc_row_t   rows [6] = '{'{8'h3b, 1'b0, 8'h00, 8'hfd}, '{8'h3c, 1'b0, 8'h00, 8'h99},
    '{8'h3c, 1'b1, 8'h5a, 8'h5a}, '{8'h3b, 1'b1, 8'h00, 8'h75},
    '{8'h3b, 1'b1, 8'hff, 8'hfd}, '{8'h40, 1'b1, 8'h12, 8'h00}};
  // ==========================================================================
  // Clock and device
  always #12.5 clk = ~clk;
  dbtc_top #(.FREQ_W(16)) dut (.CLK(clk), .RST_N(rst_n), .REG_REQ(req), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .LOOP_LOCKED(locked), .INTEG_AT_LIMIT(at_lim), .LOOP_FREQ(freq),
    .TRIM_HIGH(trim_hi), .USE_ACQ_BW(use_acq), .INTEG_HOLD(hold), .REPORTED_FREQ(rep_freq),
    .CAL_VALUE(cal));
  // ==========================================================================
  // Shared tasks
  // Inputs move 2 ns after the edge so sampling never races the drive
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access plus an idle cycle, so req is never assigned twice at once
  task automatic access(input logic [7:0] a, input logic w, input logic r,
                        input logic [7:0] d, input logic [7:0] exp);
    req = '{addr: a, wr: w, rd: r, wdata: d};
    tick(1);
    if (r)
    begin
      chk(rd_valid, 16'h0001);
      chk(rd_data, exp);
    end
    req = '0;
    tick(1);
    if (r)
      chk(rd_valid, 16'h0000);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    tick(12);
    rst_n = 1'b1;
    tick(1);
    chk(cal, 16'h9999);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        access(rows[i].addr, 1'b1, 1'b0, rows[i].wdata, 8'h00);
      access(rows[i].addr, 1'b0, 1'b1, 8'h00, rows[i].exp);
    end
    // Same-cycle read and write returns the old byte
    access(8'h3c, 1'b1, 1'b1, 8'hc3, 8'h5a);
    trim_hi = 8'ha5;
    tick(2);
    chk(cal, 16'ha5c3);
    // Auto-pick on: loop state chooses the bandwidth
    locked = 1'b0;
    tick(2);
    chk(use_acq, 16'h0001);
    locked = 1'b1;
    tick(2);
    chk(use_acq, 16'h0000);
    // Freeze on: integral and reported frequency stop at the limit
    freq = 16'h1234;
    tick(2);
    at_lim = 1'b1;
    tick(1);
    freq = 16'h5678;
    tick(2);
    chk(hold, 16'h0001);
    chk(rep_freq, 16'h1234);
    at_lim = 1'b0;
    tick(3);
    chk(rep_freq, 16'h5678);
    // Both bits cleared: locked bandwidth always, no freeze
    access(8'h3b, 1'b1, 1'b0, 8'h00, 8'h00);
    locked = 1'b0;
    at_lim = 1'b1;
    freq = 16'h9abc;
    tick(2);
    chk(use_acq, 16'h0000);
    chk(hold, 16'h0000);
    chk(rep_freq, 16'h9abc);
    // Second reset mid-run restores the defaults
    rst_n = 1'b0;
    tick(2);
    chk(rd_valid, 16'h0000);
    chk(use_acq, 16'h0000);
    chk(hold, 16'h0000);
    chk(rep_freq, 16'h0000);
    chk(cal, 16'h9999);
    rst_n = 1'b1;
    tick(1);
    // Defaults turn auto-pick and freeze on, so the unlocked loop at its limit reacts at once
    chk(use_acq, 16'h0001);
    chk(hold, 16'h0001);
    chk(rep_freq, 16'h0000);
    chk(cal, 16'ha599);
    access(8'h3c, 1'b0, 1'b1, 8'h00, 8'h99);
    access(8'h3b, 1'b0, 1'b1, 8'h00, 8'hfd);
    finish_test();
  end
endmodule
`default_nettype wire
